// *** logic/rcic_pkg.sv ***
// Purpose: Constants for the reset-cause and interrupt control block
// Assumes: Avalon-MM slave, 32-bit data, word addressed by byte address
// Notes: Byte address is four times the register index
package rcic_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_WATCHDOG_CTRL = 8'h0e;
    localparam logic [7:0] IDX_PENDING = 8'h0f;
    localparam logic [7:0] IDX_MASK = 8'h10;
    localparam logic [7:0] IDX_STATUS = 8'h11;
    localparam logic [7:0] IDX_CMD = 8'h12;
    localparam logic [7:0] IDX_PORT_CFG = 8'h13;
    // Flag bit positions
    localparam int TIMER_BIT = 0;
    localparam int PORT_BIT = 1;
    localparam int EXT_BIT = 2;
    // Control register fields
    localparam int WATCHDOG_RUN_BIT = 7;
    localparam int EXT_SEL_BIT = 6;
    // Status register fields
    localparam int ST_TIMEOUT_BIT = 4;
    localparam int ST_PWRDN_BIT = 3;
    localparam int ST_GIE_BIT = 0;
    localparam int ST_SLEEP_BIT = 1;
    // Command register bits (write one to issue)
    localparam int CMD_GIE_ON = 0;
    localparam int CMD_GIE_OFF = 1;
    localparam int CMD_RETURN = 2;
    localparam int CMD_SLEEP = 3;
    localparam int CMD_WATCHDOG_CLEAR = 4;
    localparam int CMD_TRAP = 5;
    localparam int CMD_PORT_READ = 6;
    // Vectors
    localparam logic [9:0] IRQ_VECTOR = 10'h008;
    localparam logic [9:0] TRAP_VECTOR = 10'h001;
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h80;
    localparam logic [2:0] FLAGS_RESET = 3'h0;
endpackage : rcic_pkg

// *** logic/rcic_edge_detect.sv ***
// Purpose: Falling-edge detector on an already synchronous level
// Assumes: input is in the clk domain
// Notes: Reset level high so a low input at release reads as a falling edge
`timescale 1ns/1ps
module rcic_edge_detect (
    // Clock and reset
    input wire logic clk,
    input wire logic rstN,
    // Level in, pulse out
    input wire logic level,
    output logic fall
);
    logic prev;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            prev <= 1'b1;
        end else begin
            prev <= level;
        end
    end

    assign fall = prev & ~level;
endmodule : rcic_edge_detect

// *** logic/rcic_top.sv ***
// Purpose: Reset-cause tracking, interrupt flags, masking and fetch redirect
// Assumes: Core issues ops through the command register; pins are asynchronous
// Notes: Writes finish at once; a read holds one wait state for its data flop
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module rcic_top #(
    parameter int PORT_W = 8
) (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic arst_n,
    // Avalon-MM slave
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic [1:0] response,
    // Asynchronous event pins
    input wire logic resetPinN,
    input wire logic watchdogExpire,
    input wire logic timerOverflowN,
    input wire logic [PORT_W-1:0] port6Pins,
    // Port direction: 1 means output
    input wire logic [PORT_W-1:0] port6IsOutput,
    // Core side
    output logic coreReset,
    output logic irqRequest,
    output logic fetchRedirect,
    output logic [9:0] fetchVector,
    output logic coreSleeping,
    output logic watchdogRun
);
    logic rstMeta;
    logic rstN;
    logic [1:0] pinSyncA;
    logic pinSyncB;
    logic [1:0] dogSyncA;
    logic dogSyncB;
    logic [PORT_W-1:0] portMeta;
    logic [PORT_W-1:0] portSync;
    logic [PORT_W-1:0] portRef;
    logic [1:0] tmrSync;
    logic pinSync;
    logic pinFall;
    logic dogRise;
    logic extFall;
    logic tmrFall;
    logic portChange;
    logic [PORT_W-1:0] portWatch;
    logic [7:0] ctrlReg;
    logic [2:0] pendingFlags;
    logic [2:0] sourceMask;
    logic [2:0] next_pendingFlags;
    logic timeoutFlag;
    logic pwrDownFlag;
    logic globalIrqOn;
    logic sleeping;
    logic softReset;
    logic wrStrobe;
    logic [7:0] regIdx;
    logic [2:0] irqVector;
    logic [6:0] cmd;
    logic rdDone;

    // Power-on reset released through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pinSyncA <= 2'h3;
            pinSyncB <= 1'b1;
            dogSyncA <= 2'h0;
            dogSyncB <= 1'b0;
            portMeta <= '0;
            portSync <= '0;
            tmrSync <= 2'h3;
        end else begin
            pinSyncA <= {pinSyncA[0], resetPinN};
            // Third stage holds last cycle's level for the event detect
            pinSyncB <= pinSyncA[1];
            dogSyncA <= {dogSyncA[0], watchdogExpire};
            dogSyncB <= dogSyncA[1];
            portMeta <= port6Pins;
            portSync <= portMeta;
            tmrSync <= {tmrSync[0], timerOverflowN};
        end
    end

    assign pinSync = pinSyncA[1];
    // Reset pin event fires on the rising edge ending a low pulse
    // One-cycle events, so coreReset is a single pulse
    assign pinFall = pinSync & ~pinSyncB;
    assign dogRise = dogSyncA[1] & ~dogSyncB & watchdogRun;

    rcic_edge_detect uExtEdge (
        .clk(clk),
        .rstN(rstN),
        .level(portSync[0] | ~ctrlReg[rcic_pkg::EXT_SEL_BIT]),
        .fall(extFall)
    );

    rcic_edge_detect uTmrEdge (
        .clk(clk),
        .rstN(rstN),
        .level(tmrSync[1]),
        .fall(tmrFall)
    );

    always_comb begin
        portWatch = ~port6IsOutput;
        if (ctrlReg[rcic_pkg::EXT_SEL_BIT]) begin
            portWatch[0] = 1'b0;
        end
    end
    assign portChange = |((portSync ^ portRef) & portWatch);

    // Reset sources; pin and watchdog reset the core
    assign softReset = pinFall | dogRise;

    // Bus decode; word address from byte address
    assign regIdx = address[9:2];
    assign wrStrobe = write & byteenable[0];
    assign cmd = (wrStrobe && regIdx == rcic_pkg::IDX_CMD) ? writedata[6:0] : 7'h00;

    // Reads stall one cycle so readdata stands when waitrequest drops
    // Costs a cycle per read but keeps the data output a flop
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rdDone <= 1'b0;
        end else begin
            rdDone <= read & ~rdDone;
        end
    end
    assign waitrequest = read & ~rdDone;

    // Reference loaded by port read op
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            portRef <= '0;
        end else if (cmd[rcic_pkg::CMD_PORT_READ]) begin
            portRef <= portSync;
        end
    end

    // Control register; watchdog run forced on at every reset and wake
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ctrlReg <= rcic_pkg::CTRL_RESET;
        end else if (softReset) begin
            ctrlReg <= rcic_pkg::CTRL_RESET;
        end else if (sleeping && sourceMask[rcic_pkg::PORT_BIT] && portChange) begin
            ctrlReg[rcic_pkg::WATCHDOG_RUN_BIT] <= 1'b1;
        end else if (wrStrobe && regIdx == rcic_pkg::IDX_WATCHDOG_CTRL) begin
            ctrlReg[rcic_pkg::WATCHDOG_RUN_BIT] <= writedata[rcic_pkg::WATCHDOG_RUN_BIT];
            ctrlReg[rcic_pkg::EXT_SEL_BIT] <= writedata[rcic_pkg::EXT_SEL_BIT];
            ctrlReg[4] <= writedata[4];
        end
    end
    assign watchdogRun = ctrlReg[rcic_pkg::WATCHDOG_RUN_BIT];

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            sourceMask <= 3'h0;
        end else if (softReset) begin
            sourceMask <= 3'h0;
        end else if (wrStrobe && regIdx == rcic_pkg::IDX_MASK) begin
            sourceMask <= writedata[2:0];
        end
    end

    // Timer and external set unmasked; port change masked
    always_comb begin
        next_pendingFlags = pendingFlags;
        if (wrStrobe && regIdx == rcic_pkg::IDX_PENDING) begin
            next_pendingFlags = writedata[2:0];
        end
        if (tmrFall) begin
            next_pendingFlags[rcic_pkg::TIMER_BIT] = 1'b1;
        end
        if (extFall) begin
            next_pendingFlags[rcic_pkg::EXT_BIT] = 1'b1;
        end
        if (portChange && sourceMask[rcic_pkg::PORT_BIT]) begin
            next_pendingFlags[rcic_pkg::PORT_BIT] = 1'b1;
        end
    end

    // Cleared by any reset, kept across change wake
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pendingFlags <= rcic_pkg::FLAGS_RESET;
        end else if (softReset) begin
            pendingFlags <= rcic_pkg::FLAGS_RESET;
        end else begin
            pendingFlags <= next_pendingFlags;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            globalIrqOn <= 1'b0;
        end else if (softReset) begin
            globalIrqOn <= 1'b0;
        end else if (cmd[rcic_pkg::CMD_GIE_ON] || cmd[rcic_pkg::CMD_RETURN]) begin
            globalIrqOn <= 1'b1;
        end else if (cmd[rcic_pkg::CMD_GIE_OFF] || fetchRedirect) begin
            globalIrqOn <= 1'b0;
        end
    end

    // Sleep left only by pin, watchdog or change
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            sleeping <= 1'b0;
        end else if (softReset) begin
            sleeping <= 1'b0;
        end else if (sleeping && sourceMask[rcic_pkg::PORT_BIT] && portChange) begin
            sleeping <= 1'b0;
        end else if (cmd[rcic_pkg::CMD_SLEEP]) begin
            sleeping <= 1'b1;
        end
    end
    assign coreSleeping = sleeping;

    // Timeout and power-down flags
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            timeoutFlag <= 1'b1;
            pwrDownFlag <= 1'b1;
        end else if (dogRise) begin
            timeoutFlag <= 1'b0;
            if (sleeping) begin
                pwrDownFlag <= 1'b0;
            end
        end else if (pinFall) begin
            if (sleeping) begin
                timeoutFlag <= 1'b1;
                pwrDownFlag <= 1'b0;
            end
        end else if (sleeping && sourceMask[rcic_pkg::PORT_BIT] && portChange) begin
            timeoutFlag <= 1'b1;
            pwrDownFlag <= 1'b0;
        end else if (cmd[rcic_pkg::CMD_WATCHDOG_CLEAR]) begin
            timeoutFlag <= 1'b1;
            pwrDownFlag <= 1'b1;
        end else if (cmd[rcic_pkg::CMD_SLEEP]) begin
            timeoutFlag <= 1'b1;
            pwrDownFlag <= 1'b0;
        end
    end

    assign irqVector = pendingFlags & sourceMask;

    // Fetch redirect; trap outranks a source interrupt
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            fetchRedirect <= 1'b0;
            fetchVector <= 10'h000;
            irqRequest <= 1'b0;
            coreReset <= 1'b1;
        end else begin
            coreReset <= softReset;
            irqRequest <= |irqVector;
            fetchRedirect <= 1'b0;
            if (cmd[rcic_pkg::CMD_TRAP] && globalIrqOn) begin
                fetchRedirect <= 1'b1;
                fetchVector <= rcic_pkg::TRAP_VECTOR;
            end else if (globalIrqOn && !sleeping && !fetchRedirect && |irqVector) begin
                // Interrupt vector, also after change wake
                fetchRedirect <= 1'b1;
                fetchVector <= rcic_pkg::IRQ_VECTOR;
            end
        end
    end

    // Read mux, loaded in the stall cycle
    // Holds until the next read, so the master sees it when the stall ends
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            readdata <= 32'h0000_0000;
            response <= 2'h0;
        end else if (read && !rdDone) begin
            response <= 2'h0;
            unique case (regIdx)
                rcic_pkg::IDX_WATCHDOG_CTRL: readdata <= {24'h000000, ctrlReg[7:6], 1'b0,
                                                         ctrlReg[4], 4'h0};
                rcic_pkg::IDX_PENDING: readdata <= {29'h0, pendingFlags};
                rcic_pkg::IDX_MASK: readdata <= {29'h0, sourceMask};
                rcic_pkg::IDX_STATUS: readdata <= {27'h0, timeoutFlag, pwrDownFlag, 1'b0,
                                                   sleeping, globalIrqOn};
                rcic_pkg::IDX_PORT_CFG: readdata <= {24'h000000, 8'(portSync)};
                default: begin
                    readdata <= 32'h0000_0000;
                    response <= 2'h2;
                end
            endcase
        end
    end
endmodule : rcic_top

// *** tb/rcic_top_sva.sv ***
// Purpose: Port-level checks for rcic_top
// Assumes: Async pins reach the core within a few cycles
// Notes: Sees only top ports
`timescale 1ns/1ps
module rcic_top_sva #(
    parameter int PORT_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Bus
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [1:0] response,
    // Events and core side
    input wire logic resetPinN,
    input wire logic watchdogExpire,
    input wire logic watchdogRun,
    input wire logic coreReset,
    input wire logic irqRequest,
    input wire logic fetchRedirect,
    input wire logic [9:0] fetchVector,
    input wire logic coreSleeping
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic [7:0] idx;
    assign idx = address[9:2];
    wait_one_a: assert property (waitrequest |-> read ##1 !waitrequest)
        else $error("read stall not one cycle");
    wr_no_wait_a: assert property (!read |-> !waitrequest)
        else $error("waitrequest raised without a read");
    vec_ok_a: assert property (fetchRedirect |->
        fetchVector == rcic_pkg::IRQ_VECTOR || fetchVector == rcic_pkg::TRAP_VECTOR)
        else $error("bad fetch vector");
    redir_pulse_a: assert property (fetchRedirect |=> !fetchRedirect)
        else $error("redirect longer than one cycle");
    pin_reset_a: assert property ($rose(resetPinN) |-> ##[1:8] coreReset)
        else $error("no reset after pin pulse");
    dog_reset_a: assert property (
        $rose(watchdogExpire) && watchdogRun |-> ##[1:8] coreReset)
        else $error("no reset after watchdog expiry");
    irq_clear_a: assert property ($rose(coreReset) |-> ##[1:4] !irqRequest)
        else $error("request survives reset");
    unmap_rd_a: assert property (read && !waitrequest &&
        (idx < rcic_pkg::IDX_WATCHDOG_CTRL || idx > rcic_pkg::IDX_PORT_CFG)
        |-> response == 2'b10 && readdata == 32'h0)
        else $error("unmapped read answer wrong");
    map_rd_a: assert property (read && !waitrequest &&
        idx >= rcic_pkg::IDX_WATCHDOG_CTRL && idx <= rcic_pkg::IDX_STATUS
        |-> response == 2'b00)
        else $error("mapped read flagged");
    cover property ($fell(coreSleeping));
    cover property (fetchRedirect && fetchVector == rcic_pkg::TRAP_VECTOR);
    cover property ($rose(irqRequest));
endmodule : rcic_top_sva

bind rcic_top rcic_top_sva #(.PORT_W(PORT_W)) i_sva (.clk(clk), .arst_n(arst_n),
    .address(address), .read(read), .readdata(readdata), .waitrequest(waitrequest),
    .response(response), .resetPinN(resetPinN), .watchdogExpire(watchdogExpire),
    .watchdogRun(watchdogRun), .coreReset(coreReset), .irqRequest(irqRequest),
    .fetchRedirect(fetchRedirect), .fetchVector(fetchVector), .coreSleeping(coreSleeping));

// *** tb/rcic_top_tb.sv ***
// Purpose: Directed bench for rcic_top
// Assumes: Pin events settle within ten cycles
// Notes: Tests share the state each one leaves
`timescale 1ns/1ps
module rcic_top_tb;
    localparam logic [9:0] CT = {rcic_pkg::IDX_WATCHDOG_CTRL, 2'b00};
    localparam logic [9:0] FL = {rcic_pkg::IDX_PENDING, 2'b00};
    localparam logic [9:0] MK = {rcic_pkg::IDX_MASK, 2'b00};
    localparam logic [9:0] ST = {rcic_pkg::IDX_STATUS, 2'b00};
    localparam logic [9:0] CM = {rcic_pkg::IDX_CMD, 2'b00};
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [9:0] address = 10'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'h1;
    logic resetPinN = 1'b1;
    logic watchdogExpire = 1'b0;
    logic timerOverflowN = 1'b1;
    logic [7:0] port6Pins = 8'hff;
    logic [7:0] port6IsOutput = 8'h00;
    logic [31:0] readdata;
    logic [1:0] response;
    logic [9:0] fetchVector;
    logic waitrequest, coreReset, irqRequest, fetchRedirect, coreSleeping, watchdogRun;
    logic [31:0] r;
    int errors = 0;
    int compares = 0;
    always #2.5 clk = ~clk;
    rcic_top #(.PORT_W(8)) i_dut (.clk(clk), .arst_n(arst_n), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .response(response),
        .resetPinN(resetPinN), .watchdogExpire(watchdogExpire),
        .timerOverflowN(timerOverflowN), .port6Pins(port6Pins),
        .port6IsOutput(port6IsOutput), .coreReset(coreReset), .irqRequest(irqRequest),
        .fetchRedirect(fetchRedirect), .fetchVector(fetchVector),
        .coreSleeping(coreSleeping), .watchdogRun(watchdogRun));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Request held until waitrequest is seen low; read data taken at that edge
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        write <= w;
        read <= !w;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        r = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask : bus
    task automatic settle;
        repeat (10) @(posedge clk);
    endtask : settle
    task automatic op(input int b);
        bus(1'b1, CM, 32'h1 << b);
    endtask : op
    task automatic tp(input logic [1:0] e);
        bus(1'b0, ST, 32'h0);
        chk("timeout,powerdown", e, r[4:3]);
    endtask : tp
    task automatic redir(input logic [9:0] v);
        int n;
        n = 0;
        while (fetchRedirect !== 1'b1 && n < 30) begin
            @(negedge clk);
            n++;
        end
        chk("fetchVector", v, fetchRedirect === 1'b1 ? fetchVector : 10'h3ff);
    endtask : redir
    task automatic wdog;
        watchdogExpire <= 1'b1;
        settle;
        watchdogExpire <= 1'b0;
        settle;
    endtask : wdog
    task automatic pinrst;
        resetPinN <= 1'b0;
        settle;
        resetPinN <= 1'b1;
        settle;
    endtask : pinrst
    task automatic t_power;
        tp(2'b11);
        bus(1'b0, FL, 32'h0);
        chk("flags", 32'h0, r[2:0]);
        bus(1'b0, CT, 32'h0);
        chk("ctrl", 2'b10, r[7:6]);
        chk("watchdogRun", 1'b1, watchdogRun);
        byteenable <= 4'h0;
        bus(1'b1, MK, 32'h7);
        byteenable <= 4'h1;
        bus(1'b0, MK, 32'h0);
        chk("lane off write", 32'h0, r);
        bus(1'b0, 10'h3fc, 32'h0);
        chk("response", 2'b10, response);
        chk("unmapped", 32'h0, r);
        $display("power test done");
    endtask : t_power
    task automatic t_timer;
        timerOverflowN <= 1'b0;
        settle;
        bus(1'b0, FL, 32'h0);
        chk("timer flag", 1'b1, r[0]);
        chk("irq masked", 1'b0, irqRequest);
        bus(1'b1, MK, 32'h1);
        settle;
        chk("irq unmasked", 1'b1, irqRequest);
        op(rcic_pkg::CMD_GIE_ON);
        redir(rcic_pkg::IRQ_VECTOR);
        bus(1'b1, FL, 32'h0);
        timerOverflowN <= 1'b1;
        op(rcic_pkg::CMD_RETURN);
        bus(1'b0, ST, 32'h0);
        chk("enable", 1'b1, r[0]);
        op(rcic_pkg::CMD_TRAP);
        redir(rcic_pkg::TRAP_VECTOR);
        op(rcic_pkg::CMD_GIE_OFF);
        bus(1'b0, ST, 32'h0);
        chk("disable", 1'b0, r[0]);
        bus(1'b1, MK, 32'h0);
        $display("timer test done");
    endtask : t_timer
    task automatic t_ext;
        bus(1'b1, CT, 32'hc0);
        port6Pins[0] <= 1'b0;
        settle;
        bus(1'b0, FL, 32'h0);
        chk("ext flag", 3'h4, r[2:0]);
        bus(1'b1, FL, 32'h0);
        port6Pins[0] <= 1'b1;
        bus(1'b1, CT, 32'h80);
        $display("ext test done");
    endtask : t_ext
    task automatic t_wdt;
        op(rcic_pkg::CMD_WATCHDOG_CLEAR);
        tp(2'b11);
        wdog;
        tp(2'b01);
        op(rcic_pkg::CMD_SLEEP);
        tp(2'b10);
        chk("sleeping", 1'b1, coreSleeping);
        wdog;
        tp(2'b00);
        chk("awake", 1'b0, coreSleeping);
        $display("watchdog test done");
    endtask : t_wdt
    task automatic t_pin;
        timerOverflowN <= 1'b0;
        settle;
        pinrst;
        tp(2'b00);
        bus(1'b0, FL, 32'h0);
        chk("flags after reset", 32'h0, r[2:0]);
        timerOverflowN <= 1'b1;
        op(rcic_pkg::CMD_SLEEP);
        pinrst;
        tp(2'b10);
        chk("pin wake", 1'b0, coreSleeping);
        $display("pin reset test done");
    endtask : t_pin
    task automatic t_port;
        port6IsOutput <= 8'h10;
        op(rcic_pkg::CMD_PORT_READ);
        bus(1'b1, MK, 32'h2);
        op(rcic_pkg::CMD_SLEEP);
        port6Pins[4] <= 1'b0;
        settle;
        chk("output pin ignored", 1'b1, coreSleeping);
        port6Pins[3] <= 1'b0;
        settle;
        chk("change wake", 1'b0, coreSleeping);
        tp(2'b10);
        bus(1'b0, FL, 32'h0);
        chk("port flag", 3'h2, r[2:0]);
        bus(1'b1, MK, 32'h0);
        port6Pins <= 8'hff;
        bus(1'b1, FL, 32'h0);
        op(rcic_pkg::CMD_PORT_READ);
        bus(1'b1, MK, 32'h2);
        op(rcic_pkg::CMD_GIE_ON);
        op(rcic_pkg::CMD_SLEEP);
        port6Pins[3] <= 1'b0;
        redir(rcic_pkg::IRQ_VECTOR);
        $display("port change test done");
    endtask : t_port
    task automatic tally_and_finish;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (5) @(posedge clk);
        t_power;
        t_timer;
        t_ext;
        t_wdt;
        t_pin;
        t_port;
        tally_and_finish;
    end
    // Tests need about 1.3 us; this cuts a hang
    initial begin
        #30000;
        errors++;
        tally_and_finish;
    end
endmodule : rcic_top_tb
